// >>> hw/rt_event_pkg.sv
// constants for the terminal event bits block
// assumes an axi4-lite master with 32-bit data and word-aligned registers
package rt_event_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_PEND = 12'h009;
  localparam logic [11:0] IDX_EN = 12'h012;
  localparam logic [11:0] IDX_OE = 12'h016;
  localparam logic [11:0] IDX_CFG = 12'h017;
  localparam logic [11:0] IDX_STAT = 12'h040;
  localparam logic [11:0] IDX_MASK = 12'h041;
  localparam logic [11:0] IDX_CPRE = 12'h042;
  localparam logic [11:0] IDX_ILLO = 12'h043;
  localparam logic [11:0] IDX_ILHI = 12'h044;
  localparam logic [11:0] IDX_CTRL = 12'h045;
  // event bit positions in the enable, pending and output-enable words
  localparam int BIT_RESET = 8;
  localparam int BIT_INDEX = 7;
  localparam int BIT_ILLEGAL = 6;
  // writable bits: 8..3; bit 9 and 15..10 and 2..0 stay zero
  localparam logic [15:0] EVT_WMASK = 16'h01F8;
  localparam logic [15:0] PEND_CLEAR = 16'h0000;
  localparam int CFG_AUTO_BIT = 0;
  localparam int CTRL_CLR_BIT = 0;
  // sticky status bits for the system interrupt
  localparam int ST_RESET = 0;
  localparam int ST_INDEX = 1;
  localparam int ST_ILLEGAL = 2;
  // command word fields
  localparam int CMD_TR_BIT = 10;
  localparam int CMD_SA_HI = 9;
  localparam int CMD_SA_LO = 5;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // true when a byte address selects the register at the given index
  function automatic logic regHit(input logic [11:0] addr, input logic [11:0] idx);
    regHit = (addr[11:2] == idx[9:0]) && (addr[1:0] == 2'h0);
  endfunction
endpackage

// >>> hw/rt_illegal_table.sv
// illegalization table: one bit per direction and subaddress
// assumes writes come from the register slave on the same clock
`timescale 1ns/1ps
module rt_illegal_table
  import rt_event_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // host writes
  input wire logic wrLo,
  input wire logic wrHi,
  input wire logic [31:0] wrData,
  // lookup
  input wire logic [15:0] cmdWord,
  output logic illegal,
  output logic [63:0] tableBits
);
  // whole state in one struct
  typedef struct packed {
    logic [63:0] bits; // a one marks an illegal command
  } table_t;

  table_t state_reg;
  table_t state_next;

  // index from direction bit and subaddress; broadcast shares the entry
  function automatic logic [5:0] tableIndex(input logic [15:0] w);
    tableIndex = {w[CMD_TR_BIT], w[CMD_SA_HI:CMD_SA_LO]};
  endfunction

  // host loads the two halves
  always_comb
  begin
    state_next = state_reg;
    if (wrLo)
    begin
      state_next.bits[31:0] = wrData;
    end
    if (wrHi)
    begin
      state_next.bits[63:32] = wrData;
    end
  end

  // all entries legal after reset
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign illegal = state_reg.bits[tableIndex(cmdWord)];
  assign tableBits = state_reg.bits;
endmodule

// >>> hw/rt_event_bits.sv
// terminal event bits 15..6: reset command, index zero, illegal command
// assumes event strobes come from terminal logic on clk_sys, one cycle each
// Notes on behaviour
// - bits 15 to 10 unused, read zero
// - bit 9 ignores writes, reads zero
// - valid reset command raises bit 8 event
// - disabled reset event: config bit 0 picks handling
// - disabled reset event still drives reset-needed pin
// - broadcast reset command also drives reset-needed pin
// - indexed mode: index one to zero raises bit 7
// - circular mode: preset message count raises bit 7
// - table bit one marks command illegal, bit 6
// - illegal command: message error status, no data
// - disabled illegal event leaves pending and irq alone
// - enabled events OR into pending register
// - pending read returns contents then clears
// - enabling a bit ignores earlier events
// - output-enabled pending event drives irq at completion
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module rt_event_bits
  import rt_event_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // axi4-lite write address and data
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // terminal event strobes
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  input wire logic resetCmdDone,
  input wire logic cmdBroadcast,
  input wire logic idxDecrement,
  input wire logic idxCountOne,
  input wire logic circMsgDone,
  input wire logic msgDone,
  // terminal and host outputs
  output logic irqN,
  output logic resetNeeded,
  output logic autoReset,
  output logic messageErrorFlag,
  output logic noDataWords,
  output logic terminalPendingSummary,
  output logic intr
);
  // whole block state
  typedef struct packed {
    logic awRdy; // write address slot free
    logic wRdy; // write data slot free
    logic awHave; // write address held
    logic [11:0] awAddr;
    logic wHave; // write data held
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] enable; // event enable
    logic [15:0] pending; // latched enabled events
    logic [15:0] outEn; // events that reach the host pin
    logic [15:0] cfgWord; // terminal configuration; bit 0 picks reset handling
    logic [15:0] capture; // events of the message in progress
    logic [2:0] status; // sticky system events
    logic [2:0] mask;
    logic [7:0] circPreset;
    logic [7:0] circCount;
    logic irqN; // host interrupt, active low, idle high so the pin comes from a flop
    logic resetNeeded;
    logic autoReset;
    logic msgErr;
    logic noData;
    logic summary;
    logic intr;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic illegalBit; // table lookup for the current command word
  logic [63:0] tableBits; // table contents for read-back
  logic tblWrLo; // write strobes into the table
  logic tblWrHi;

  // keep only writable event bits; bit 9 and upper bits never store
  function automatic logic [15:0] evtWrite(input logic [15:0] d);
    evtWrite = d & EVT_WMASK;
  endfunction

  // register the write into the table only when the write completes
  assign tblWrLo = state_reg.awHave && state_reg.wHave && !state_reg.bValid
                   && regHit(state_reg.awAddr, IDX_ILLO);
  assign tblWrHi = state_reg.awHave && state_reg.wHave && !state_reg.bValid
                   && regHit(state_reg.awAddr, IDX_ILHI);

  rt_illegal_table illegalTable (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrLo(tblWrLo),
    .wrHi(tblWrHi),
    .wrData(state_reg.wData),
    .cmdWord(cmdWord),
    .illegal(illegalBit),
    .tableBits(tableBits)
  );

  // next-state logic for bus slave and event bits
  always_comb
  begin
    logic [15:0] raw; // events seen this cycle, before enable
    logic [15:0] newEvt; // enabled events this cycle
    logic [15:0] msgEvt; // everything this message raised
    logic readPend; // pending read handshake this cycle
    logic doWrite;
    logic [7:0] cnt;
    logic [31:0] rd;
    logic hit;
    raw = '0;
    newEvt = '0;
    msgEvt = '0;
    readPend = 1'b0;
    doWrite = 1'b0;
    cnt = '0;
    rd = '0;
    hit = 1'b1;
    state_next = state_reg;
    state_next.autoReset = 1'b0;
    // write channels taken in either order
    if (awvalid && state_reg.awRdy)
    begin
      state_next.awHave = 1'b1;
      state_next.awAddr = awaddr;
    end
    if (wvalid && state_reg.wRdy)
    begin
      state_next.wHave = 1'b1;
      state_next.wData = wdata;
      state_next.wStrb = wstrb;
    end
    if (state_reg.bValid && bready)
    begin
      state_next.bValid = 1'b0;
    end
    doWrite = state_reg.awHave && state_reg.wHave && !state_reg.bValid;
    if (doWrite)
    begin
      state_next.awHave = 1'b0;
      state_next.wHave = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = RESP_OKAY;
      // only the low half word matters, except the table halves take all 32 bits; write strobes are not used
      if (regHit(state_reg.awAddr, IDX_EN))
      begin
        state_next.enable = evtWrite(state_reg.wData[15:0]);
      end
      else if (regHit(state_reg.awAddr, IDX_OE))
      begin
        state_next.outEn = evtWrite(state_reg.wData[15:0]);
      end
      else if (regHit(state_reg.awAddr, IDX_CFG))
      begin
        state_next.cfgWord = state_reg.wData[15:0];
      end
      else if (regHit(state_reg.awAddr, IDX_MASK))
      begin
        state_next.mask = state_reg.wData[2:0];
      end
      else if (regHit(state_reg.awAddr, IDX_CPRE))
      begin
        state_next.circPreset = state_reg.wData[7:0];
      end
      else if (regHit(state_reg.awAddr, IDX_CTRL))
      begin
        if (state_reg.wData[CTRL_CLR_BIT])
        begin
          state_next.resetNeeded = 1'b0;
        end
      end
      else if (regHit(state_reg.awAddr, IDX_STAT) || regHit(state_reg.awAddr, IDX_PEND)
               || regHit(state_reg.awAddr, IDX_ILLO) || regHit(state_reg.awAddr, IDX_ILHI))
      begin
        // pending ignores writes; status is write-one-to-clear below
      end
      else
      begin
        state_next.bResp = RESP_DECERR;
      end
    end
    // status clears first so a same-cycle event below wins
    if (doWrite && regHit(state_reg.awAddr, IDX_STAT))
    begin
      state_next.status = state_reg.status & ~state_reg.wData[2:0];
    end
    state_next.awRdy = !state_next.awHave && !state_next.bValid;
    state_next.wRdy = !state_next.wHave && !state_next.bValid;
    // read channel: one outstanding, answered the cycle after
    if (state_reg.rValid && rready)
    begin
      state_next.rValid = 1'b0;
    end
    if (arvalid && state_reg.arRdy)
    begin
      if (regHit(araddr, IDX_PEND))
      begin
        rd = {16'h0000, state_reg.pending};
        readPend = 1'b1;
      end
      else if (regHit(araddr, IDX_EN))
      begin
        rd = {16'h0000, state_reg.enable};
      end
      else if (regHit(araddr, IDX_OE))
      begin
        rd = {16'h0000, state_reg.outEn};
      end
      else if (regHit(araddr, IDX_CFG))
      begin
        rd = {16'h0000, state_reg.cfgWord};
      end
      else if (regHit(araddr, IDX_STAT))
      begin
        rd = {29'h0000000, state_reg.status};
      end
      else if (regHit(araddr, IDX_MASK))
      begin
        rd = {29'h0000000, state_reg.mask};
      end
      else if (regHit(araddr, IDX_CPRE))
      begin
        rd = {24'h000000, state_reg.circPreset};
      end
      else if (regHit(araddr, IDX_ILLO))
      begin
        rd = tableBits[31:0];
      end
      else if (regHit(araddr, IDX_ILHI))
      begin
        rd = tableBits[63:32];
      end
      else if (regHit(araddr, IDX_CTRL))
      begin
        rd = {31'h00000000, state_reg.resetNeeded};
      end
      else
      begin
        hit = 1'b0;
      end
      state_next.rValid = 1'b1;
      state_next.rData = rd;
      state_next.rResp = hit ? RESP_OKAY : RESP_DECERR;
    end
    state_next.arRdy = !state_next.rValid;
    // raw events of this cycle
    raw[BIT_RESET] = resetCmdDone;
    raw[BIT_INDEX] = idxDecrement && idxCountOne;
    cnt = state_reg.circCount + 8'h01;
    if (circMsgDone)
    begin
      if (cnt == state_reg.circPreset)
      begin
        raw[BIT_INDEX] = 1'b1;
        cnt = 8'h00;
      end
      state_next.circCount = cnt;
    end
    raw[BIT_ILLEGAL] = cmdValid && illegalBit;
    // enable is sampled at the event, so late enabling misses it
    newEvt = raw & state_reg.enable;
    msgEvt = state_reg.capture | newEvt;
    // illegal command answer
    if (cmdValid)
    begin
      state_next.msgErr = illegalBit;
      state_next.noData = illegalBit;
    end
    // reset command: pin when the event is off or on broadcast, handling choice when the event is off
    if (resetCmdDone && (!state_reg.enable[BIT_RESET] || cmdBroadcast))
    begin
      state_next.resetNeeded = 1'b1;
    end
    if (resetCmdDone && !state_reg.enable[BIT_RESET])
    begin
      state_next.autoReset = state_reg.cfgWord[CFG_AUTO_BIT];
    end
    // pending: read clear first, then message results OR in
    if (readPend)
    begin
      state_next.pending = PEND_CLEAR;
      state_next.irqN = 1'b1;
    end
    if (msgDone)
    begin
      state_next.pending = state_next.pending | msgEvt;
      state_next.capture = '0;
      if ((msgEvt & state_reg.outEn) != 16'h0000)
      begin
        state_next.irqN = 1'b0;
      end
    end
    else
    begin
      state_next.capture = msgEvt;
    end
    // sticky system status, set wins over a same-cycle clear
    state_next.status[ST_RESET] = state_next.status[ST_RESET] | raw[BIT_RESET];
    state_next.status[ST_INDEX] = state_next.status[ST_INDEX] | raw[BIT_INDEX];
    state_next.status[ST_ILLEGAL] = state_next.status[ST_ILLEGAL] | raw[BIT_ILLEGAL];
    state_next.intr = |(state_next.status & state_next.mask);
    state_next.summary = |state_next.pending;
  end

  // single register stage for all state
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // everything clear, host interrupt pin released high
      state_reg <= '{irqN: 1'b1, default: '0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign awready = state_reg.awRdy;
  assign wready = state_reg.wRdy;
  assign bvalid = state_reg.bValid;
  assign bresp = state_reg.bResp;
  assign arready = state_reg.arRdy;
  assign rvalid = state_reg.rValid;
  assign rdata = state_reg.rData;
  assign rresp = state_reg.rResp;
  assign irqN = state_reg.irqN;
  assign resetNeeded = state_reg.resetNeeded;
  assign autoReset = state_reg.autoReset;
  assign messageErrorFlag = state_reg.msgErr;
  assign noDataWords = state_reg.noData;
  assign terminalPendingSummary = state_reg.summary;
  assign intr = state_reg.intr;

  // checks
  AST_RSV_BITS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state_reg.pending[15:9] == 7'h00) && (state_reg.enable[15:9] == 7'h00))
    else $error("reserved event bits set");
  AST_PEND_OR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (msgDone && !(arvalid && arready && regHit(araddr, IDX_PEND)))
    |=> ((state_reg.pending & $past(state_reg.pending)) == $past(state_reg.pending)))
    else $error("pending lost a bit");
  AST_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (arvalid && arready && regHit(araddr, IDX_PEND) && !msgDone)
    |=> (state_reg.pending == PEND_CLEAR) && rvalid && (rdata[15:0] == $past(state_reg.pending)))
    else $error("pending read did not clear");
  AST_RESET_PIN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (resetCmdDone && !state_reg.enable[BIT_RESET]) |=> resetNeeded)
    else $error("reset pin not driven");
  AST_BCAST_PIN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (resetCmdDone && cmdBroadcast) |=> resetNeeded)
    else $error("broadcast reset pin not driven");
  AST_AUTO_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (resetCmdDone && !state_reg.enable[BIT_RESET])
    |=> (autoReset == $past(state_reg.cfgWord[CFG_AUTO_BIT])))
    else $error("reset handling choice wrong");
  AST_ILLEGAL_ME: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cmdValid |=> (messageErrorFlag == $past(illegalBit)) && (noDataWords == messageErrorFlag))
    else $error("illegal answer wrong");
  AST_ILL_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cmdValid && illegalBit && !state_reg.enable[BIT_ILLEGAL] && !msgDone)
    |=> (state_reg.capture[BIT_ILLEGAL] == $past(state_reg.capture[BIT_ILLEGAL])))
    else $error("disabled illegal event captured");
  AST_IDX_EVT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (idxDecrement && idxCountOne && state_reg.enable[BIT_INDEX] && !msgDone)
    |=> state_reg.capture[BIT_INDEX])
    else $error("index zero event missed");
  AST_IRQ_DONE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (msgDone && ((state_reg.capture & state_reg.outEn) != 16'h0000)) |=> !irqN)
    else $error("irq not asserted at completion");
endmodule

// >>> tb/host_model.sv
// host side of the register bus: an axi4-lite master with blocking tasks
// assumes one caller at a time and the bench timeout to end any hang
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk_sys,
  // write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {12'h000, 12'h000, 32'h0000_0000, 4'hF};
  end

  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge clk_sys);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      // released lines carry the inverse so stale values never look valid
      if (!aw && awready === 1'b1)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w && wready === 1'b1)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    // bready stays high until the response is sampled
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // one read; rready held until rvalid is sampled
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// >>> tb/rt_event_bits_tb_top.sv
// bench top for the terminal event bits block
// assumes host_model speaks the register bus; strobes are driven here
`timescale 1ns/1ps
`define CHK(g, e, m) begin checkCount++; if ((g) !== (e)) begin nMismatch++; $display("BAD %0t %s", $time, m); end end
module rt_event_bits_tb_top;
  import rt_event_pkg::*;
  // t/r 1, subaddress 1: table bit 33, high word bit 1
  localparam logic [15:0] ILL_CMD = 16'h0420;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  // event strobes, all idle at time zero
  logic cmdValid = 1'b0, resetCmdDone = 1'b0, cmdBroadcast = 1'b0, idxDecrement = 1'b0;
  logic idxCountOne = 1'b0, circMsgDone = 1'b0, msgDone = 1'b0;
  logic [15:0] cmdWord = ILL_CMD;
  logic irqN, resetNeeded, autoReset, messageErrorFlag, noDataWords;
  logic terminalPendingSummary, intr;
  int nMismatch = 0;
  int checkCount = 0;
  int cycles = 0;

  rt_event_bits u_rt_event_bits (.clk_sys, .rst_b, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .cmdValid, .cmdWord, .resetCmdDone, .cmdBroadcast,
    .idxDecrement, .idxCountOne, .circMsgDone, .msgDone, .irqN, .resetNeeded, .autoReset,
    .messageErrorFlag, .noDataWords, .terminalPendingSummary, .intr);

  host_model u_host_model (.clk_sys, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);

  // 8 ns clock
  initial
    forever #4 clk_sys = ~clk_sys;

  // hang guard: the whole run needs a few hundred cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nMismatch++;
      $display("BAD %0t timeout", $time);
      wrapUp();
    end
  end

  // register index to byte address
  function automatic logic [11:0] ba(input logic [11:0] idx);
    return {idx[9:0], 2'h0};
  endfunction

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [1:0] r;
    u_host_model.wr(ba(idx), d, r);
    `CHK(r, RESP_OKAY, "write response")
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [15:0] e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    u_host_model.rd(ba(idx), d, r);
    `CHK(d, {16'h0000, e}, m)
  endtask

  // one-cycle strobes: bit0 cmd, 1 reset, 2 bcast, 3 idx, 4 one, 5 circ, 6 done
  task automatic pulse(input logic [6:0] s);
    @(posedge clk_sys);
    {msgDone, circMsgDone, idxCountOne, idxDecrement, cmdBroadcast, resetCmdDone, cmdValid} <= s;
    @(posedge clk_sys);
    {msgDone, circMsgDone, idxCountOne, idxDecrement, cmdBroadcast, resetCmdDone, cmdValid} <= 7'h00;
    #1;
  endtask

  // lets pending and irq land after a completion
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic test_regs;
    logic [31:0] d;
    logic [1:0] r;
    rdchk(IDX_EN, 16'h0000, "enable reset");
    wr(IDX_EN, 32'h0000_FFFF);
    rdchk(IDX_EN, EVT_WMASK, "enable bits");
    wr(IDX_PEND, 32'h0000_FFFF);
    rdchk(IDX_PEND, 16'h0000, "pending write");
    u_host_model.rd(12'h3FC, d, r);
    `CHK(r, RESP_DECERR, "unmapped read")
    $display("test regs done");
  endtask

  task automatic test_illegal;
    wr(IDX_ILHI, 32'h0000_0002);
    wr(IDX_EN, 32'h0000_0040);
    wr(IDX_OE, 32'h0000_0040);
    wr(IDX_MASK, 32'h0000_0004);
    pulse(7'h01);
    `CHK(messageErrorFlag, 1'b1, "error flag")
    `CHK(noDataWords, 1'b1, "no data")
    pulse(7'h40);
    settle();
    `CHK(irqN, 1'b0, "irq low")
    `CHK(terminalPendingSummary, 1'b1, "summary")
    `CHK(intr, 1'b1, "system irq")
    rdchk(IDX_PEND, 16'h0040, "pending illegal");
    rdchk(IDX_PEND, 16'h0000, "pending cleared");
    `CHK(irqN, 1'b1, "irq released")
    cmdWord <= 16'h0020;
    pulse(7'h01);
    `CHK(messageErrorFlag, 1'b0, "legal command")
    wr(IDX_STAT, 32'h0000_0004);
    #1;
    `CHK(intr, 1'b0, "status cleared")
    $display("test illegal done");
  endtask

  task automatic test_disabled;
    cmdWord <= ILL_CMD;
    wr(IDX_EN, 32'h0000_0000);
    // illegal command while disabled, enable raised before the message completes
    pulse(7'h01);
    `CHK(messageErrorFlag, 1'b1, "still rejected")
    wr(IDX_EN, 32'h0000_0040);
    pulse(7'h40);
    settle();
    `CHK(irqN, 1'b1, "disabled irq")
    rdchk(IDX_PEND, 16'h0000, "late enable");
    $display("test disabled done");
  endtask

  task automatic test_reset_cmd;
    wr(IDX_EN, 32'h0000_0000);
    wr(IDX_CFG, 32'h0000_0001);
    pulse(7'h02);
    `CHK(autoReset, 1'b1, "auto reset")
    `CHK(resetNeeded, 1'b1, "reset pin")
    pulse(7'h40);
    settle();
    `CHK(irqN, 1'b1, "reset no irq")
    rdchk(IDX_PEND, 16'h0000, "reset no pending");
    wr(IDX_CTRL, 32'h0000_0001);
    wr(IDX_CFG, 32'h0000_0000);
    pulse(7'h02);
    `CHK(autoReset, 1'b0, "host reset")
    wr(IDX_CTRL, 32'h0000_0001);
    #1;
    `CHK(resetNeeded, 1'b0, "pin cleared")
    wr(IDX_EN, 32'h0000_0100);
    wr(IDX_OE, 32'h0000_0100);
    pulse(7'h06);
    `CHK(resetNeeded, 1'b1, "broadcast pin")
    pulse(7'h40);
    settle();
    `CHK(irqN, 1'b0, "reset irq")
    rdchk(IDX_PEND, 16'h0100, "reset pending");
    wr(IDX_CTRL, 32'h0000_0001);
    $display("test reset done");
  endtask

  task automatic test_index;
    wr(IDX_EN, 32'h0000_01C0);
    wr(IDX_CPRE, 32'h0000_0002);
    pulse(7'h18);
    pulse(7'h41);
    settle();
    rdchk(IDX_PEND, 16'h00C0, "or into pending");
    pulse(7'h48);
    settle();
    rdchk(IDX_PEND, 16'h0000, "count not one");
    pulse(7'h60);
    settle();
    rdchk(IDX_PEND, 16'h0000, "circ first");
    pulse(7'h63);
    settle();
    rdchk(IDX_PEND, 16'h01C0, "all together");
    $display("test index done");
  endtask

  // closing report, shared by the main flow and the hang guard
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reset for 20 cycles, then the scenarios
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_regs();
    test_illegal();
    test_disabled();
    test_reset_cmd();
    test_index();
    wrapUp();
  end
endmodule
